// *** sim/ext_clk_src.sv ***
// Model of the external clock source on the timer pins
`timescale 1ns/10ps
module ext_clk_src #(
   parameter int HALF = 3
) (
   // System clock
   input wire logic clk,
   // Burst request
   input wire logic go,
   input wire logic [7:0] periods,
   // Pin level
   output logic pin
);
   logic [8:0] left_q = 9'h000;
   logic [3:0] cnt_q = 4'h0;
   initial pin = 1'b0;
   // idle low, each half period lasts HALF clocks
   always @(posedge clk) begin
      if (go) begin
         left_q <= {periods, 1'b0};
         cnt_q <= 4'h0;
      end else if (left_q != 9'h000) begin
         cnt_q <= (cnt_q == HALF - 1) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q == HALF - 1) begin
            pin <= ~pin;
            left_q <= left_q - 9'h001;
         end
      end
   end
endmodule // ext_clk_src

// *** sim/timer_prescaler_clock_select_flags_tb_top.sv ***
// Self-checking bench for the timer prescaler and flags block
`timescale 1ns/10ps
module timer_prescaler_clock_select_flags_tb_top;
   import tmr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   avs_req_s req = '0;
   logic [31:0] rdata, q;
   logic wreq, pin, irq_c, irq_o;
   logic gie = 1'b0, ack_c = 1'b0, ack_o = 1'b0, go = 1'b0;
   logic ovf = 1'b0, rev = 1'b0, pwm = 1'b0;
   logic [7:0] cval = 8'h01;
   logic [5:0] oth = 6'h00;
   logic [1:0] tick;
   int err_total = 0, checks = 0, cyc = 0, t0 = 0, t1 = 0, b0, b1;
   int dv[4] = '{8, 64, 256, 1024};
   always #25 clk = ~clk;
   timer_prescaler_clock_select_flags dut (.CLK(clk), .RST_N(rst_n),
      .AVS_REQ(req), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
      .EXT_CLK_PIN_ZERO(pin), .EXT_CLK_PIN_ONE(pin),
      .GLOBAL_IRQ_EN(gie), .VEC_ACK_CMP0(ack_c), .VEC_ACK_OVF0(ack_o),
      .CNT0_VALUE(cval), .CNT0_OVF(ovf), .CNT0_REV_BOTTOM(rev),
      .PHASE_PWM0(pwm), .OTHER_FLAG_SET(oth), .TIMER_TICK(tick),
      .IRQ_CMP0(irq_c), .IRQ_OVF0(irq_o));
   ext_clk_src #(.HALF(3)) src (.clk(clk), .go(go), .periods(8'h05),
      .pin(pin));
   always @(posedge clk) begin
      t0 <= t0 + tick[0];
      t1 <= t1 + tick[1];
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      req <= '{read: ~wr, write: wr, address: a, writedata: d};
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdata;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge clk);
      b0 = t0;
      b1 = t1;
   endtask
   task automatic t_reset();
      bus(1'b0, 4'h0, 32'h0);
      chk("flags", 32'h0, q);
      bus(1'b0, 4'h4, 32'h0);
      chk("ctrl", 32'h0, q);
      bus(1'b0, 4'h1, 32'h0);
      chk("unmapped", 32'h0, q);
   endtask
   task automatic t_flags();
      bus(1'b1, 4'h8, 32'h5a);
      oth <= 6'h3f;
      ovf <= 1'b1;
      cval <= 8'h5a;
      @(posedge clk);
      oth <= 6'h00;
      ovf <= 1'b0;
      cval <= 8'h00;
      bus(1'b0, 4'h0, 32'h0);
      chk("flags set", 32'hff, q);
      bus(1'b1, 4'h0, 32'h0f);
      bus(1'b0, 4'h0, 32'h0);
      chk("flags w1c", 32'hf0, q);
      bus(1'b1, 4'h0, 32'hf0);
      pwm <= 1'b1;
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      bus(1'b0, 4'h0, 32'h0);
      chk("pwm ovf", 32'h0, q);
      rev <= 1'b1;
      @(posedge clk);
      rev <= 1'b0;
      bus(1'b0, 4'h0, 32'h0);
      chk("pwm bottom", 32'h1, q);
      bus(1'b1, 4'h0, 32'h1);
      pwm <= 1'b0;
   endtask
   task automatic t_irq();
      bus(1'b1, 4'h4, 32'h300);
      ovf <= 1'b1;
      cval <= 8'h5a;
      @(posedge clk);
      ovf <= 1'b0;
      cval <= 8'h00;
      edges(2);
      chk("irq no gie", 32'h0, {irq_c, irq_o});
      gie <= 1'b1;
      edges(3);
      chk("irq gie", 32'h3, {irq_c, irq_o});
      ack_o <= 1'b1;
      @(posedge clk);
      ack_o <= 1'b0;
      edges(3);
      chk("irq ack ovf", 32'h2, {irq_c, irq_o});
      ack_c <= 1'b1;
      @(posedge clk);
      ack_c <= 1'b0;
      edges(3);
      chk("irq ack cmp", 32'h0, {irq_c, irq_o});
      gie <= 1'b0;
   endtask
   task automatic t_taps();
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 4'h4, 32'h8 + 32'(i + 2));
         edges(3);
         repeat (2 * dv[i]) @(posedge clk);
         chk("tap ticks", 32'h2, 32'(t0 - b0));
         chk("direct ticks", 32'(2 * dv[i]), 32'(t1 - b1));
      end
   endtask
   task automatic t_presc();
      bus(1'b1, 4'h4, 32'h1001a);
      edges(2);
      repeat (6) bus(1'b1, 4'h4, 32'h1001a);
      chk("reset t0", 32'h0, 32'(t0 - b0));
      chk("reset t1", 32'h0, 32'(t1 - b1));
      bus(1'b0, 4'h4, 32'h0);
      chk("reset bit", 32'h1a, q);
      edges(1);
      repeat (16) @(posedge clk);
      chk("after reset", 32'h2, 32'(t0 - b0));
   endtask
   task automatic t_pin();
      bus(1'b1, 4'h4, 32'h37);
      edges(3);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (40) @(posedge clk);
      chk("pin rise", 32'h5, 32'(t0 - b0));
      chk("pin fall", 32'h5, 32'(t1 - b1));
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_flags();
      t_irq();
      t_taps();
      t_presc();
      t_pin();
      results();
   end
endmodule // timer_prescaler_clock_select_flags_tb_top

// *** src/timer_prescaler_clock_select_flags.sv ***
// Shared prescaler, clock select, pin sync and timer-zero flags
`timescale 1ns/10ps
`include "tmr_consts.svh"
module timer_prescaler_clock_select_flags (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Register bus
   input wire tmr_pkg::avs_req_s AVS_REQ,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // External clock pins
   input wire logic EXT_CLK_PIN_ZERO,
   input wire logic EXT_CLK_PIN_ONE,
   // Core and counter side
   input wire logic GLOBAL_IRQ_EN,
   input wire logic VEC_ACK_CMP0,
   input wire logic VEC_ACK_OVF0,
   input wire logic [7:0] CNT0_VALUE,
   input wire logic CNT0_OVF,
   input wire logic CNT0_REV_BOTTOM,
   input wire logic PHASE_PWM0,
   input wire logic [5:0] OTHER_FLAG_SET,
   // Timer count enables and interrupts
   output logic [1:0] TIMER_TICK,
   output logic IRQ_CMP0,
   output logic IRQ_OVF0
);
   import tmr_pkg::*;

   logic wait_q;
   logic [31:0] rdata_q;
   logic acc;
   logic wr_acc;
   logic wr_flags;
   logic wr_ctrl;
   logic wr_cmp0;
   logic presc_rst;
   ctrl_s ctrl_q;
   logic [7:0] cmp0_value_q;
   logic [7:0] flags_q;
   logic [7:0] flags_set;
   logic [7:0] flags_clr;
   logic match_q;
   logic cmp_set;
   logic ovf_set;
   logic [`PRESC_W-1:0] presc_q;
   logic [3:0] tap_en;
   logic [1:0] pin_raw;
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] pin_s3_q;
   logic [1:0] tick_q;
   logic irq_cmp0_q;
   logic irq_ovf0_q;
   clk_sel_e sel [2];

   // Bus: one wait cycle, then accept
   assign acc = (AVS_REQ.read | AVS_REQ.write) & ~wait_q;
   assign wr_acc = AVS_REQ.write & ~wait_q;
   assign wr_flags = wr_acc && AVS_REQ.address == `OFS_FLAGS;
   assign wr_ctrl = wr_acc && AVS_REQ.address == `OFS_CTRL;
   assign wr_cmp0 = wr_acc && AVS_REQ.address == `OFS_CMP0;
   assign presc_rst = wr_ctrl & AVS_REQ.writedata[`CTRL_PRESC_RST_BIT];

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wait_q <= 1'b1;
      end else if (acc) begin
         wait_q <= 1'b1;
      end else if (AVS_REQ.read | AVS_REQ.write) begin
         wait_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_q <= 32'h0;
      end else if (AVS_REQ.read && wait_q) begin
         case (AVS_REQ.address)
            `OFS_FLAGS: rdata_q <= {24'h0, flags_q};
            `OFS_CTRL: rdata_q <= {22'h0, ctrl_q.cmp0_irq_en,
               ctrl_q.ovf0_irq_en, 2'h0, ctrl_q.clk_sel1, ctrl_q.clk_sel0};
            `OFS_CMP0: rdata_q <= {24'h0, cmp0_value_q};
            `OFS_PRESC: rdata_q <= {22'h0, presc_q};
            default: rdata_q <= 32'h0;
         endcase
      end
   end

   assign AVS_READDATA = rdata_q;
   assign AVS_WAITREQUEST = wait_q;

   // Control and compare value registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q <= `CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_s'({AVS_REQ.writedata[`CTRL_CMP0_EN_BIT],
            AVS_REQ.writedata[`CTRL_OVF0_EN_BIT],
            AVS_REQ.writedata[5:0]});
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cmp0_value_q <= `CMP0_RST;
      end else if (wr_cmp0) begin
         cmp0_value_q <= AVS_REQ.writedata[7:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         match_q <= 1'b0;
      end else begin
         match_q <= CNT0_VALUE == cmp0_value_q;
      end
   end
   assign cmp_set = (CNT0_VALUE == cmp0_value_q) & ~match_q;
   assign ovf_set = PHASE_PWM0 ? CNT0_REV_BOTTOM : CNT0_OVF;

   assign flags_set = {OTHER_FLAG_SET, cmp_set, ovf_set};
   // clear by vector or write one
   assign flags_clr = (wr_flags ? AVS_REQ.writedata[7:0] : 8'h00)
      | {6'h00, VEC_ACK_CMP0, VEC_ACK_OVF0};

   // Set wins over clear
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         flags_q <= `FLAGS_RST;
      end else begin
         flags_q <= (flags_q & ~flags_clr) | flags_set;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_cmp0_q <= 1'b0;
         irq_ovf0_q <= 1'b0;
      end else begin
         irq_cmp0_q <= GLOBAL_IRQ_EN & ctrl_q.cmp0_irq_en
            & flags_q[`FLAG_CMP0_BIT];
         irq_ovf0_q <= GLOBAL_IRQ_EN & ctrl_q.ovf0_irq_en
            & flags_q[`FLAG_OVF0_BIT];
      end
   end
   assign IRQ_CMP0 = irq_cmp0_q;
   assign IRQ_OVF0 = irq_ovf0_q;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         presc_q <= '0;
      end else if (presc_rst) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_q + 10'h001;
      end
   end

   assign tap_en[0] = presc_q[2:0] == `TAP8_END;
   assign tap_en[1] = presc_q[5:0] == `TAP64_END;
   assign tap_en[2] = presc_q[7:0] == `TAP256_END;
   assign tap_en[3] = presc_q == `TAP1024_END;

   assign pin_raw = {EXT_CLK_PIN_ONE, EXT_CLK_PIN_ZERO};
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         pin_s3_q <= 2'h0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign sel[0] = clk_sel_e'(ctrl_q.clk_sel0);
   assign sel[1] = clk_sel_e'(ctrl_q.clk_sel1);

   for (genvar t = 0; t < 2; t++) begin : g_sel
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            tick_q[t] <= 1'b0;
         end else begin
            case (sel[t])
               SEL_STOP: tick_q[t] <= 1'b0;
               SEL_DIRECT: tick_q[t] <= 1'b1;
               SEL_DIV8: tick_q[t] <= tap_en[0];
               SEL_DIV64: tick_q[t] <= tap_en[1];
               SEL_DIV256: tick_q[t] <= tap_en[2];
               SEL_DIV1024: tick_q[t] <= tap_en[3];
               SEL_PIN_FALL: tick_q[t] <= pin_s3_q[t] & ~pin_s2_q[t];
               SEL_PIN_RISE: tick_q[t] <= pin_s2_q[t] & ~pin_s3_q[t];
               default: tick_q[t] <= 1'b0;
            endcase
         end
      end
   end
   assign TIMER_TICK = tick_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   AST_OVF_IRQ_GATE: assert property (
      IRQ_OVF0 |-> $past(GLOBAL_IRQ_EN) && $past(ctrl_q.ovf0_irq_en))
      else $error("overflow irq without enables");
   AST_CMP_SET: assert property (
      cmp_set |=> flags_q[`FLAG_CMP0_BIT])
      else $error("compare flag not set on match");
   AST_VEC_CLR: assert property (
      VEC_ACK_CMP0 && !cmp_set |=> !flags_q[`FLAG_CMP0_BIT])
      else $error("compare flag not cleared by vector");
   AST_CMP_IRQ: assert property (
      GLOBAL_IRQ_EN && ctrl_q.cmp0_irq_en && flags_q[`FLAG_CMP0_BIT]
      |=> IRQ_CMP0)
      else $error("compare irq missing");
   AST_PWM_OVF: assert property (
      PHASE_PWM0 && CNT0_REV_BOTTOM |=> flags_q[`FLAG_OVF0_BIT])
      else $error("overflow flag not set at bottom turn");
   AST_DIRECT: assert property (
      sel[0] == SEL_DIRECT |=> TIMER_TICK[0])
      else $error("direct select missed a tick");
   AST_TAP8_SPACING: assert property (
      tap_en[0] |=> !tap_en[0] [*7])
      else $error("divide by 8 tap spacing wrong");
   AST_PRESC_RST: assert property (
      presc_rst |=> presc_q == 10'h000 ##1 ctrl_q == $past(ctrl_q))
      else $error("prescaler not restarted");
   AST_PIN_RISE: assert property (
      pin_s2_q[0] && !pin_s3_q[0] && sel[0] == SEL_PIN_RISE
      |=> TIMER_TICK[0] ##1 !TIMER_TICK[0])
      else $error("rising pin edge not one tick");
   AST_BUS_WAIT: assert property (
      (AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST)
      else $error("bus answer late");

   COV_PIN_FALL: cover property (sel[0] == SEL_PIN_FALL && TIMER_TICK[0]);
   COV_TAP1024: cover property (sel[1] == SEL_DIV1024 && TIMER_TICK[1]);
   COV_SET_CLR: cover property (cmp_set && VEC_ACK_CMP0);
   COV_PRESC_RST: cover property (presc_rst);
endmodule // timer_prescaler_clock_select_flags

// *** src/tmr_consts.svh ***
// Constants for the shared timer prescaler, clock select and flags
// How it works
// - Overflow-0 interrupt raised only with its enable and global enable set.
// - Flag register: eight bits, reset zero, compare2 down to overflow0.
// - Compare-0 flag (bit 1) sets when counter equals compare value.
// - Compare-0 flag clears on vector execution or software writing one.
// - Compare-0 interrupt needs global enable, its enable and its flag.
// - Overflow-0 flag (bit 0) sets on overflow, clears like compare flag.
// - In phase correct PWM, overflow-0 sets at direction change at zero.
// - Both timers share one prescaler, each picks its own tap.
// - Clock select 1 counts every system clock.
// - Prescaler taps divide system clock by 8, 64, 256, 1024.
// - Prescaler free running; first prescaled count comes 1 to N+1 later.
// - Prescaler reset restarts the period for both timers.
// - Pin sampled every clock through synchronising flops, then edge detect.
// - Select 7 counts rising pin edges, select 6 falling edges.
// - Pin edge reaches the counter within 2.5 to 3.5 clocks; here TIMER_TICK pulses 2 to 3 clocks after the edge.
// - Pin clock edges never pass through the prescaler.
// - Prescaler reset bit: write one resets, self clears, reads zero.
// - Select: 0 stop, 1 direct, 2-5 taps, 6 fall, 7 rise.
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define OFS_FLAGS 4'h0
`define OFS_CTRL 4'h4
`define OFS_CMP0 4'h8
`define OFS_PRESC 4'hc
`define FLAGS_RST 8'h00
`define CTRL_RST 8'h00
`define CMP0_RST 8'h00
`define CTRL_SEL0_LSB 0
`define CTRL_SEL1_LSB 3
`define CTRL_OVF0_EN_BIT 8
`define CTRL_CMP0_EN_BIT 9
`define CTRL_PRESC_RST_BIT 16
`define FLAG_OVF0_BIT 0
`define FLAG_CMP0_BIT 1
`define PRESC_W 10
`define TAP8_END 10'h007
`define TAP64_END 10'h03f
`define TAP256_END 10'h0ff
`define TAP1024_END 10'h3ff
`endif

// *** src/tmr_pkg.sv ***
// Types for the shared timer prescaler block
package tmr_pkg;
   typedef enum logic [2:0] {
      SEL_STOP = 3'b000,
      SEL_DIRECT = 3'b001,
      SEL_DIV8 = 3'b010,
      SEL_DIV64 = 3'b011,
      SEL_DIV256 = 3'b100,
      SEL_DIV1024 = 3'b101,
      SEL_PIN_FALL = 3'b110,
      SEL_PIN_RISE = 3'b111
   } clk_sel_e;
   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } avs_req_s;
   typedef struct packed {
      logic cmp0_irq_en;
      logic ovf0_irq_en;
      logic [2:0] clk_sel1;
      logic [2:0] clk_sel0;
   } ctrl_s;
endpackage
